// File: common/vphy_regs_defines.vh
/*
  constants for the emulated phy expansion and special control/status registers.
  assumes the including file supplies the register access logic.
*/
// Functional notes
// - the expansion register sits at system offset 0x1d8 and management index 6.
// - registers are 32 bits in the system map with a zero upper half, 16 bits serially.
// - the parallel detection fault bit 4 always reads 0.
// - partner and local next-page-able bits 3 and 2 always read 0.
// - page received bit 1 latches on a new page and clears when the register is read.
// - page received is cleared by reset and set again once negotiation has run.
// - partner negotiation-able bit 0 reads 1 unless negotiation finds no common ability.
// - the special control/status register sits at offset 0x1dc and management index 31.
// - bit 14 loops port 0 transmit frames back into the switch instead of the mii; resets 0.
// - bit 7 drives collision to port 0 while the switch transmits on it; resets 0.
// - bits 4:2 report the current speed and duplex; code 000 is reserved.
// - speed/duplex comes from the negotiation result when enabled, else from basic control.
// - soft-reset-clearable control bits return to defaults on an emulated phy reset.
`ifndef VPHY_REGS_DEFINES_VH
`define VPHY_REGS_DEFINES_VH
`define OFS_AN_EXP 12'h1d8
`define OFS_SPECIAL 12'h1dc
`define MIDX_AN_EXP 5'h06
`define MIDX_SPECIAL 5'h1f
`define EXP_PAGE_BIT 1
`define EXP_LP_AN_BIT 0
`define SPC_LOOP_BIT 14
`define SPC_COLL_BIT 7
`define SPC_SD_LSB 2
`define SD_10_HALF 3'h1
`define SD_100_HALF 3'h2
`define SD_10_FULL 3'h5
`define SD_100_FULL 3'h6
`define SPC_SD_MSB 4
`define NIBBLE_W 4
`define HALF_ZERO 16'h0000
`define WORD_ZERO 32'h00000000
`define NIBBLE_RST 4'h0
`define BIT_RST 1'b0
`define PAGE_RST 1'b0
`define LP_AN_RST 1'b0
`define LOOP_RST 1'b0
`define COLL_RST 1'b0
`define SD_RST 3'h1
`endif

// File: hdl/vphy_status_regs.v
/*
  expansion and special control/status registers of the emulated phy, with the
  port 0 far loopback and forced collision steering.
  assumes the negotiation engine, basic control and a system/management access
  front end outside; accesses are single-cycle strobes synchronous to CLK_SYS.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vphy_regs_defines.vh"
module vphy_status_regs (
  // clock and resets
  input wire CLK_SYS,
  input wire RST,
  input wire VPHY_SOFT_RST,
  // system map access
  input wire SYS_RD,
  input wire SYS_WR,
  input wire [11:0] SYS_ADDR,
  input wire [31:0] SYS_WDATA,
  output reg [31:0] SYS_RDATA,
  // management serial access
  input wire MDIO_RD,
  input wire MDIO_WR,
  input wire [4:0] MDIO_REG,
  input wire [15:0] MDIO_WDATA,
  output reg [15:0] MDIO_RDATA,
  // negotiation engine and basic control
  input wire PAGE_RX,
  input wire AN_FAIL,
  input wire AUTONEG_ENABLE,
  input wire AN_SPEED_100,
  input wire AN_FULL_DUPLEX,
  input wire SPEED_SELECT_LOW_BIT,
  input wire DUPLEX_SELECT,
  // switch port 0 datapath
  input wire P0_TX_EN,
  input wire [3:0] P0_TXD,
  output reg MII_TX_EN,
  output reg [3:0] MII_TXD,
  output reg P0_RX_DV,
  output reg [3:0] P0_RXD,
  output reg P0_COL
);
  // stored state and next values
  reg page_rx_r;
  reg page_rx_nxt;
  reg lp_an_r;
  reg lp_an_nxt;
  reg loop_r;
  reg loop_nxt;
  reg coll_r;
  reg coll_nxt;
  reg [2:0] sd_r;
  reg [2:0] sd_nxt;
  // read images, low half only
  reg [15:0] exp_val;
  reg [15:0] spc_val;
  reg [15:0] sys_sel;
  reg [15:0] mdio_sel;
  // decode
  wire sys_exp;
  wire sys_spc;
  wire mdio_exp;
  wire mdio_spc;
  wire exp_read;
  wire spc_wr_sys;
  wire spc_wr_mdio;
  wire spc_wr;
  wire [15:0] wdata;
  // port 0 steering next values
  wire mii_tx_en_nxt;
  wire p0_rx_dv_nxt;
  wire p0_col_nxt;
  wire [3:0] mii_txd_nxt;
  wire [3:0] p0_rxd_nxt;

  assign sys_exp = (SYS_ADDR == `OFS_AN_EXP);
  assign sys_spc = (SYS_ADDR == `OFS_SPECIAL);
  assign mdio_exp = (MDIO_REG == `MIDX_AN_EXP);
  assign mdio_spc = (MDIO_REG == `MIDX_SPECIAL);
  // a read from either side is the clearing read
  assign exp_read = (SYS_RD & sys_exp) | (MDIO_RD & mdio_exp);
  assign spc_wr_sys = SYS_WR & sys_spc;
  assign spc_wr_mdio = MDIO_WR & mdio_spc;
  assign spc_wr = spc_wr_sys | spc_wr_mdio;
  // system side wins a same-cycle write clash
  assign wdata = spc_wr_sys ? SYS_WDATA[15:0] : MDIO_WDATA;

  // speed/duplex source select
  always @* begin
    if (AUTONEG_ENABLE) begin
      sd_nxt = {AN_FULL_DUPLEX, AN_SPEED_100, ~AN_SPEED_100};
    end else begin
      sd_nxt = {DUPLEX_SELECT, SPEED_SELECT_LOW_BIT, ~SPEED_SELECT_LOW_BIT};
    end
  end

  // set beats the clearing read, so a page in the read cycle is not lost
  always @* begin
    page_rx_nxt = page_rx_r;
    if (PAGE_RX) begin
      page_rx_nxt = 1'b1;
    end else if (exp_read) begin
      page_rx_nxt = 1'b0;
    end
  end

  always @* begin
    lp_an_nxt = ~AN_FAIL;
  end

  // soft reset beats a same-cycle write
  always @* begin
    loop_nxt = loop_r;
    coll_nxt = coll_r;
    if (VPHY_SOFT_RST) begin
      loop_nxt = `LOOP_RST;
      coll_nxt = `COLL_RST;
    end else if (spc_wr) begin
      loop_nxt = wdata[`SPC_LOOP_BIT];
      coll_nxt = wdata[`SPC_COLL_BIT];
    end
  end

  // read images; all other bits are fixed zeros
  always @* begin
    exp_val = `HALF_ZERO;
    exp_val[`EXP_PAGE_BIT] = page_rx_r;
    exp_val[`EXP_LP_AN_BIT] = lp_an_r;
    spc_val = `HALF_ZERO;
    spc_val[`SPC_LOOP_BIT] = loop_r;
    spc_val[`SPC_COLL_BIT] = coll_r;
    spc_val[`SPC_SD_MSB:`SPC_SD_LSB] = sd_r;
  end

  // unmapped addresses read zero
  always @* begin
    if (sys_exp) begin
      sys_sel = exp_val;
    end else if (sys_spc) begin
      sys_sel = spc_val;
    end else begin
      sys_sel = `HALF_ZERO;
    end
  end

  always @* begin
    if (mdio_exp) begin
      mdio_sel = exp_val;
    end else if (mdio_spc) begin
      mdio_sel = spc_val;
    end else begin
      mdio_sel = `HALF_ZERO;
    end
  end

  // loopback works with the collision test off as well
  assign mii_tx_en_nxt = P0_TX_EN & ~loop_r;
  assign p0_rx_dv_nxt = P0_TX_EN & loop_r;
  // collision without loopback is allowed; the far end then sees frames too
  assign p0_col_nxt = P0_TX_EN & coll_r;

  genvar g;
  generate
    for (g = 0; g < `NIBBLE_W; g = g + 1) begin : g_nib
      assign mii_txd_nxt[g] = P0_TXD[g] & ~loop_r;
      assign p0_rxd_nxt[g] = P0_TXD[g] & loop_r;
    end
  endgenerate

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      page_rx_r <= `PAGE_RST;
    end else begin
      page_rx_r <= page_rx_nxt;
    end
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      lp_an_r <= `LP_AN_RST;
    end else begin
      lp_an_r <= lp_an_nxt;
    end
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      loop_r <= `LOOP_RST;
      coll_r <= `COLL_RST;
    end else begin
      loop_r <= loop_nxt;
      coll_r <= coll_nxt;
    end
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sd_r <= `SD_RST;
    end else begin
      sd_r <= sd_nxt;
    end
  end

  // read data registered every cycle, whatever the strobe
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      SYS_RDATA <= `WORD_ZERO;
      MDIO_RDATA <= `HALF_ZERO;
    end else begin
      SYS_RDATA <= {`HALF_ZERO, sys_sel};
      MDIO_RDATA <= mdio_sel;
    end
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      MII_TX_EN <= `BIT_RST;
      MII_TXD <= `NIBBLE_RST;
      P0_RX_DV <= `BIT_RST;
      P0_RXD <= `NIBBLE_RST;
      P0_COL <= `BIT_RST;
    end else begin
      MII_TX_EN <= mii_tx_en_nxt;
      MII_TXD <= mii_txd_nxt;
      P0_RX_DV <= p0_rx_dv_nxt;
      P0_RXD <= p0_rxd_nxt;
      P0_COL <= p0_col_nxt;
    end
  end
endmodule
`default_nettype wire

// File: test/vphy_chk_sva.sv
/* port checker of vphy_status_regs; bound at the foot */
`timescale 1ns/1ps
`default_nettype none
module vphy_chk(input wire CLK_SYS,RST,SYS_RD,PAGE_RX,P0_TX_EN,MII_TX_EN,P0_RX_DV,P0_COL,
 input wire [11:0] SYS_ADDR,input wire [31:0] SYS_RDATA,input wire [15:0] MDIO_RDATA);
 default clocking @(posedge CLK_SYS); endclocking
 default disable iff (RST);
 wire ex=SYS_RD&&SYS_ADDR==12'h1d8&&!PAGE_RX;
 property p_hi; SYS_RDATA[31:16]==0; endproperty
 a_hi: assert property(p_hi) else $error("hi");
 property p_ex; $past(SYS_ADDR)==12'h1d8 |-> SYS_RDATA[15:2]==0; endproperty
 a_ex: assert property(p_ex) else $error("ex");
 property p_rs; MDIO_RDATA[15]==0&&MDIO_RDATA[13:8]==0&&MDIO_RDATA[6:5]==0; endproperty
 a_rs: assert property(p_rs) else $error("rs");
 property p_sd; $past(SYS_ADDR)==12'h1dc&&!$past(RST) |-> SYS_RDATA[4:2] inside {1,2,5,6};
 endproperty
 a_sd: assert property(p_sd) else $error("sd");
 property p_clr; ex ##1 ex |=> !SYS_RDATA[1]; endproperty
 a_clr: assert property(p_clr) else $error("clr");
 property p_col; P0_COL |-> $past(P0_TX_EN); endproperty
 a_col: assert property(p_col) else $error("col");
 property p_lp; P0_RX_DV |-> !MII_TX_EN&&$past(P0_TX_EN); endproperty
 a_lp: assert property(p_lp) else $error("lp");
 // collision without loopback is legal, so only the loop path excludes transmit
 property p_mii; MII_TX_EN |-> $past(P0_TX_EN)&&!P0_RX_DV; endproperty
 a_mii: assert property(p_mii) else $error("mii");
 property p_cv_clr; ex ##1 ex; endproperty
 c_clr: cover property(p_cv_clr);
 property p_cv_lp; P0_RX_DV&&P0_COL; endproperty
 c_lp: cover property(p_cv_lp);
 property p_cv_mii; MII_TX_EN; endproperty
 c_mii: cover property(p_cv_mii);
endmodule
bind vphy_status_regs vphy_chk vphy_chk_inst(.*);
`default_nettype wire

// File: test/vphy_neg_model.sv
/* engine stand-in: one page pulse soon after reset; needs CLK_SYS, RST */
`timescale 1ns/1ps
`default_nettype none
module vphy_neg_model(input wire CLK_SYS,input wire RST,output logic PAGE_RX);
 logic [2:0] cnt_r;
 always @(posedge CLK_SYS or posedge RST) cnt_r<=RST?3'h0:cnt_r+(cnt_r!=3'h7);
 assign PAGE_RX=cnt_r==3'h3;
endmodule
`default_nettype wire

// File: test/vphy_status_regs_tb.sv
/* bench of vphy_status_regs; uses vphy_neg_model */
`timescale 1ns/1ps
`default_nettype none
module vphy_status_regs_tb;
 logic CLK_SYS=0,RST=1,VPHY_SOFT_RST=0,SYS_RD=0,SYS_WR=0,MDIO_RD=0,MDIO_WR=0,AN_FAIL=0;
 logic P0_TX_EN=0,AUTONEG_ENABLE=0,AN_SPEED_100=0,AN_FULL_DUPLEX=0;
 logic SPEED_SELECT_LOW_BIT=0,DUPLEX_SELECT=0,PAGE_RX,MII_TX_EN,P0_RX_DV,P0_COL;
 logic [11:0] SYS_ADDR=0;
 logic [31:0] SYS_WDATA=0,SYS_RDATA;
 logic [15:0] MDIO_WDATA=0,MDIO_RDATA;
 logic [4:0] MDIO_REG=6;
 logic [3:0] P0_TXD=0,MII_TXD,P0_RXD;
 int n_mismatch=0,total_checks=0;
 vphy_status_regs vphy_status_regs_inst(.CLK_SYS(CLK_SYS),.RST(RST),
  .VPHY_SOFT_RST(VPHY_SOFT_RST),.SYS_RD(SYS_RD),.SYS_WR(SYS_WR),.SYS_ADDR(SYS_ADDR),
  .SYS_WDATA(SYS_WDATA),.SYS_RDATA(SYS_RDATA),.MDIO_RD(MDIO_RD),.MDIO_WR(MDIO_WR),
  .MDIO_REG(MDIO_REG),.MDIO_WDATA(MDIO_WDATA),.MDIO_RDATA(MDIO_RDATA),.PAGE_RX(PAGE_RX),
  .AN_FAIL(AN_FAIL),.AUTONEG_ENABLE(AUTONEG_ENABLE),.AN_SPEED_100(AN_SPEED_100),
  .AN_FULL_DUPLEX(AN_FULL_DUPLEX),.SPEED_SELECT_LOW_BIT(SPEED_SELECT_LOW_BIT),
  .DUPLEX_SELECT(DUPLEX_SELECT),.P0_TX_EN(P0_TX_EN),.P0_TXD(P0_TXD),.MII_TX_EN(MII_TX_EN),
  .MII_TXD(MII_TXD),.P0_RX_DV(P0_RX_DV),.P0_RXD(P0_RXD),.P0_COL(P0_COL));
 vphy_neg_model vphy_neg_model_inst(.CLK_SYS(CLK_SYS),.RST(RST),.PAGE_RX(PAGE_RX));
 always #10 CLK_SYS=~CLK_SYS;
 task chk(string s,logic [31:0] e,g);
  total_checks++;
  if (g!==e) begin
   n_mismatch++;
   $display("CHECK FAILED %s exp %h got %h",s,e,g);
  end
 endtask
 task acc(logic w,logic [11:0] a,logic [31:0] d);
  @(posedge CLK_SYS) #1 {SYS_WR,SYS_RD,SYS_ADDR,SYS_WDATA}={w,!w,a,d};
  @(posedge CLK_SYS) #1 {SYS_WR,SYS_RD}=0;
 endtask
 task macc(logic w,logic [4:0] a,logic [15:0] d);
  @(posedge CLK_SYS) #1 {MDIO_WR,MDIO_RD,MDIO_REG,MDIO_WDATA}={w,!w,a,d};
  @(posedge CLK_SYS) #1 {MDIO_WR,MDIO_RD}=0;
 endtask
 task t_page;
  @(posedge CLK_SYS) #1 {SYS_RD,SYS_ADDR}={1'b1,12'h1d8};
  @(posedge CLK_SYS) #1 chk("exp",3,SYS_RDATA);
  @(posedge CLK_SYS) #1 SYS_RD=0;
  chk("exp2",1,SYS_RDATA);
  chk("mdio",1,MDIO_RDATA);
 endtask
 task t_spd;
  for (int i=0;i<8;i++) begin
   {AUTONEG_ENABLE,AN_SPEED_100,AN_FULL_DUPLEX}={!i[2],i[1:0]^{2{i[2]}}};
   {SPEED_SELECT_LOW_BIT,DUPLEX_SELECT}=i[1:0]^{2{!i[2]}};
   acc(0,12'h1dc,0);
   chk("sd",{i[0],i[1],!i[1],2'h0},SYS_RDATA);
  end
 endtask
 task t_loop;
  acc(1,12'h1dc,32'hffffffff);
  acc(0,12'h1dc,0);
  chk("spc",32'h4098,SYS_RDATA);
  {P0_TX_EN,P0_TXD}={1'b1,4'ha};
  @(posedge CLK_SYS) #1 chk("lp",3,{MII_TX_EN,P0_RX_DV,P0_COL});
  chk("lpd",8'h0a,{MII_TXD,P0_RXD});
  VPHY_SOFT_RST=1;
  @(posedge CLK_SYS) #1 VPHY_SOFT_RST=0;
  acc(0,12'h1dc,0);
  chk("srst",32'h18,SYS_RDATA);
  chk("tx",4,{MII_TX_EN,P0_RX_DV,P0_COL});
  chk("txd",8'ha0,{MII_TXD,P0_RXD});
  AN_FAIL=1;
  acc(0,12'h1d8,0);
  chk("fail",0,SYS_RDATA);
 endtask
 task t_mdio;
  macc(1,31,16'hffff);
  macc(0,31,0);
  chk("mspc",16'h4098,MDIO_RDATA);
  macc(1,6,16'hffff);
  macc(0,6,0);
  chk("mexp",0,MDIO_RDATA);
  macc(1,31,0);
  macc(0,31,0);
  chk("mclr",16'h0018,MDIO_RDATA);
  acc(0,12'h1e0,0);
  chk("unmap",0,SYS_RDATA);
 endtask
 task t_rst;
  AN_FAIL=0;
  acc(1,12'h1dc,32'h4080);
  @(posedge CLK_SYS) #1 RST=1;
  @(posedge CLK_SYS) #1 RST=0;
  chk("rst0",0,{SYS_RDATA,MII_TX_EN,P0_RX_DV,P0_COL});
  @(posedge CLK_SYS) #1 chk("rst1",4,{MII_TX_EN,P0_RX_DV,P0_COL});
  repeat (6) @(posedge CLK_SYS);
  acc(0,12'h1d8,0);
  chk("rexp",3,SYS_RDATA);
  acc(0,12'h1dc,0);
  chk("rspc",32'h18,SYS_RDATA);
 endtask
 task summarize;
  $display("checks %0d mismatches %0d",total_checks,n_mismatch);
  if (n_mismatch==0&&total_checks>0) $display("TB: PASS");
  else $display("TB: FAIL");
  $finish;
 endtask
 initial begin
  repeat (5) @(posedge CLK_SYS);
  #1 RST=0;
  repeat (8) @(posedge CLK_SYS);
  t_page;
  t_spd;
  t_loop;
  t_mdio;
  t_rst;
  summarize;
 end
 initial begin
  #20000 n_mismatch++;
  summarize;
 end
endmodule
`default_nettype wire
